/* File: testbench/watchdog_timer_asserts.sv */
`timescale 1ns/10ps
module watchdog_timer_asserts (
  input wire mclk,
  input wire rst_n,
  input wire clkEn,
  input wire [3:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regRdata,
  input wire internalOscTick,
  input wire lowOscTick,
  input wire highOscTick,
  input wire extClockIn,
  input wire debugMode,
  input wire systemReset,
  input wire counterClock
);
  // ---------------------------------------------------------------
  // Shadow registers
  // ---------------------------------------------------------------
  // The clock and control shadows only follow writes the lock admits, so a leaky lock shows up.
  reg unlk_reg;
  reg stop_reg;
  reg [15:0] clk_reg;
  wire wOk = regWrite && clkEn && unlk_reg;
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      unlk_reg <= 1'b0;
      stop_reg <= 1'b1;
      clk_reg <= 16'h0000;
    end
    else
    begin
      if (regWrite && clkEn && regAddr == 4'h0)
        unlk_reg <= regWdata == 16'h0096;
      if (wOk && regAddr == 4'h1)
        clk_reg <= regWdata & 16'h0133;
      if (wOk && regAddr == 4'h2)
        stop_reg <= regWdata[3:0] == 4'ha;
    end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rdIdle; !regRead |=> regRdata == 16'h0000; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data leak");
  property p_keyRd; regRead && regAddr == 4'h0 |=>
    regRdata == {15'h0000, unlk_reg}; endproperty
  a_keyRd: assert property (p_keyRd) else $error("lock state");
  property p_clkRd; regRead && regAddr == 4'h1 |=> regRdata == clk_reg;
  endproperty
  a_clkRd: assert property (p_clkRd) else $error("clock setup");
  property p_ctlRd; regRead && regAddr == 4'h2 |=>
    regRdata == (stop_reg ? 16'h000a : 16'h0000); endproperty
  a_ctlRd: assert property (p_ctlRd) else $error("control read");
  property p_rstOne; systemReset |=> !systemReset; endproperty
  a_rstOne: assert property (p_rstOne) else $error("reset width");
  // The reset pulse and the counter tick that overflows are launched by
  // the same edge, so both stand in the same cycle.
  property p_rstCause; systemReset |-> counterClock; endproperty
  a_rstCause: assert property (p_rstCause) else $error("no tick");
  property p_clrSafe; wOk && regAddr == 4'h2 && regWdata[4] |=>
    !systemReset [*8]; endproperty
  a_clrSafe: assert property (p_clrSafe) else $error("clear late");
  property p_dbgGate; debugMode [*6] ##0 !clk_reg[8] |-> !counterClock;
  endproperty
  a_dbgGate: assert property (p_dbgGate) else $error("debug gate");
  property p_stopQuiet; stop_reg && $past(stop_reg, 3) |-> !systemReset;
  endproperty
  a_stopQuiet: assert property (p_stopQuiet) else $error("stopped");
  c_rst: cover property (systemReset);
  c_dbgRun: cover property (debugMode && counterClock);
  c_cntRd: cover property (regRead && regAddr == 4'h3);
endmodule
bind watchdog_timer watchdog_timer_asserts watchdog_timer_asserts_inst (
  .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .internalOscTick(internalOscTick),
  .lowOscTick(lowOscTick), .highOscTick(highOscTick),
  .extClockIn(extClockIn), .debugMode(debugMode),
  .systemReset(systemReset), .counterClock(counterClock));

/* File: testbench/watchdog_timer_test.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
  miscompares = miscompares + 1; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module watchdog_timer_test;
  reg mclk = 0, rst_n = 0, clkEn = 1, regWrite = 0, regRead = 0;
  reg debugMode = 0;
  reg [3:0] regAddr = 4'h0, tick = 4'h0, code;
  reg [15:0] regWdata = 16'h0000, key;
  wire [15:0] regRdata;
  wire systemReset, counterClock;
  integer compares = 0, miscompares = 0, seed = 49, rsts = 0, i, n;
  always #2 mclk = ~mclk;
  always @(posedge mclk) rsts <= rsts + (systemReset === 1'b1);
  watchdog_timer watchdog_timer_inst (.mclk(mclk), .rst_n(rst_n),
    .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .internalOscTick(tick[0]), .lowOscTick(tick[1]),
    .highOscTick(tick[2]), .extClockIn(tick[3]), .debugMode(debugMode),
    .systemReset(systemReset), .counterClock(counterClock));
  task bus(input w, input integer a, input [15:0] d);
  begin
    @(posedge mclk);
    regAddr <= a[3:0];
    regWdata <= d;
    regWrite <= w;
    regRead <= !w;
    @(posedge mclk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    #1;
    if (!w)
      `CHK(regRdata, d)
  end
  endtask
  // Each tick is one clock wide; the external input also needs a low gap.
  task tk(input integer s, input integer cnt);
  begin
    repeat (cnt)
    begin
      @(posedge mclk);
      tick[s] <= 1'b1;
      @(posedge mclk);
      tick[s] <= 1'b0;
      if (s == 3)
        repeat (2) @(posedge mclk);
    end
    repeat (10) @(posedge mclk);
  end
  endtask
  task report_and_stop;
  begin
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  initial
  begin
    #400000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    bus(0, 2, 16'h000a);
    bus(0, 9, 16'h0000);
    bus(1, 1, 16'hffff);
    bus(0, 1, 16'h0000);
    bus(1, 0, 16'h0096);
    bus(0, 0, 16'h0001);
    bus(1, 1, 16'hffff);
    bus(0, 1, 16'h0133);
    $display("test 1 done");
    for (i = 0; i < 4; i = i + 1)
    begin
      n = i == 1 ? 128 : i == 3 ? 1 : i == 0 ? 4096 : 2048;
      bus(1, 1, {11'h000, i == 0, 2'h0, i[1:0]});
      code = $random(seed);
      if (code == 4'ha)
        code = 4'h5;
      bus(1, 2, {12'h001, code});
      bus(0, 2, 16'h0000);
      tk(i, n - 1);
      bus(0, 3, 16'h0000);
      tk(i, 1);
      bus(0, 3, 16'h0001);
    end
    $display("test 2 done");
    @(posedge mclk) debugMode <= 1'b1;
    tk(3, 9);
    bus(0, 3, 16'h0001);
    @(posedge mclk) debugMode <= 1'b0;
    tk(3, 3);
    bus(0, 3, 16'h0004);
    bus(1, 1, 16'h0103);
    @(posedge mclk) debugMode <= 1'b1;
    tk(3, 4);
    bus(0, 3, 16'h0008);
    @(posedge mclk) debugMode <= 1'b0;
    key = $random(seed);
    bus(1, 0, key == 16'h0096 ? 16'h0000 : key);
    bus(0, 0, 16'h0000);
    bus(1, 2, 16'h001a);
    tk(3, 2);
    bus(0, 3, 16'h000a);
    bus(1, 0, 16'h0096);
    bus(1, 2, 16'h0005);
    bus(0, 3, 16'h000a);
    bus(1, 2, 16'h000a);
    tk(3, 5);
    bus(0, 3, 16'h000a);
    $display("test 3 done");
    bus(1, 2, 16'h0013);
    tk(3, 1000);
    bus(1, 2, 16'h0013);
    tk(3, 1023);
    `CHK(rsts, 0)
    tk(3, 1);
    `CHK(rsts, 1)
    bus(0, 3, 16'h0000);
    // A low clock enable must freeze the count although ticks arrive.
    @(posedge mclk) clkEn <= 1'b0;
    tk(3, 5);
    @(posedge mclk) clkEn <= 1'b1;
    bus(0, 3, 16'h0000);
    // A reset in mid-run returns the watchdog to its stopped state.
    @(posedge mclk) rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    bus(0, 2, 16'h000a);
    bus(0, 0, 16'h0000);
    $display("test 4 done");
    report_and_stop;
  end
endmodule

/* File: verilog/watchdog_map.vh */
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH
// Register indices on the plain register port.
`define WD_IDX_PROTECT 4'h0
`define WD_IDX_CLOCK 4'h1
`define WD_IDX_CONTROL 4'h2
`define WD_IDX_COUNT 4'h3
// Protection key.
`define WD_PROTECT_KEY 16'h0096
// Clock setup fields.
`define WD_DEBUG_RUN_BIT_BIT 8
`define WD_DIV_HI 5
`define WD_DIV_LO 4
`define WD_SRC_HI 1
`define WD_SRC_LO 0
// Control fields.
`define WD_CLR_BIT 4
`define WD_RUN_HI 3
`define WD_RUN_LO 0
`define WD_RUN_STOP 4'h0a
`define WD_RUN_READ_RUNNING 4'h0
// Sources.
`define WD_SRC_INTERNAL 2'h0
`define WD_SRC_LOW 2'h1
`define WD_SRC_HIGH 2'h2
`define WD_SRC_EXTERNAL 2'h3
// Division exponents: 2^11 base for internal/high, 2^7 low, 2^0 ext.
`define WD_DIV_BASE_EXP 5'd11
`define WD_DIV_LOW_EXP 5'd7
`define WD_DIV_EXT_EXP 5'd0
`define WD_PRESCALE_W 14
`endif

/* File: verilog/watchdog_timer.v */
`timescale 1ns/10ps
`include "watchdog_map.vh"

module watchdog_timer #(
  parameter COUNT_W = 10,
  parameter [3:0] SOURCES_PRESENT = 4'hf
)
(
  input wire mclk,
  input wire rst_n,
  input wire clkEn,
  input wire [3:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdata,
  input wire internalOscTick,
  input wire lowOscTick,
  input wire highOscTick,
  input wire extClockIn,
  input wire debugMode,
  output reg systemReset,
  output reg counterClock
);
  // ----------------------------------------------------------------
  // Synchronisers and register state
  // ----------------------------------------------------------------
  reg [3:0] srcMeta_reg;
  reg [3:0] srcSync_reg;
  reg extPrev_reg;
  reg dbgMeta_reg;
  reg dbgSync_reg;
  reg unlocked_reg;
  reg debugRun_reg;
  reg [1:0] divSel_reg;
  reg [1:0] srcSel_reg;
  reg stopped_reg;
  reg [COUNT_W-1:0] count_reg;
  reg clearPend_reg;
  wire divTick;
  wire wrClock;
  wire wrControl;
  wire clearCmd;
  wire srcTick;
  wire clockGated;
  reg [4:0] divExp;

  // Only the second stage of each synchroniser is ever read.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srcMeta_reg <= 4'h0;
      srcSync_reg <= 4'h0;
      extPrev_reg <= 1'b0;
      dbgMeta_reg <= 1'b0;
      dbgSync_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      srcMeta_reg <= {extClockIn, highOscTick, lowOscTick,
        internalOscTick};
      srcSync_reg <= srcMeta_reg;
      extPrev_reg <= srcSync_reg[3];
      dbgMeta_reg <= debugMode;
      dbgSync_reg <= dbgMeta_reg;
    end
  end

  function isSelectable;
    input [1:0] code;
    begin
      isSelectable = SOURCES_PRESENT[code];
    end
  endfunction

  // ----------------------------------------------------------------
  // Clock source and division
  // ----------------------------------------------------------------
  // The oscillator inputs are tick levels; the external input is a raw
  // clock, so its rising edge is taken after synchronisation.
  assign srcTick = (srcSel_reg == `WD_SRC_INTERNAL) ? srcSync_reg[0] :
    (srcSel_reg == `WD_SRC_LOW) ? srcSync_reg[1] :
    (srcSel_reg == `WD_SRC_HIGH) ? srcSync_reg[2] :
    (srcSync_reg[3] & ~extPrev_reg);

  always @*
  begin
    case (srcSel_reg)
      `WD_SRC_LOW: divExp = `WD_DIV_LOW_EXP;
      `WD_SRC_EXTERNAL: divExp = `WD_DIV_EXT_EXP;
      default: divExp = `WD_DIV_BASE_EXP + {3'b000, divSel_reg};
    endcase
  end

  // Debug mode with the debug-run bit low freezes the whole count path.
  assign clockGated = dbgSync_reg & ~debugRun_reg;

  wd_prescaler #(
    .WIDTH(`WD_PRESCALE_W)
  ) prescaler (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn & ~clockGated),
    .srcTick(srcTick),
    .exponent(divExp),
    .clear(clearPend_reg),
    .divTick(divTick)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign wrClock = regWrite & (regAddr == `WD_IDX_CLOCK) & unlocked_reg;
  assign wrControl = regWrite & (regAddr == `WD_IDX_CONTROL)
    & unlocked_reg;
  assign clearCmd = wrControl & regWdata[`WD_CLR_BIT];

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unlocked_reg <= 1'b0;
      debugRun_reg <= 1'b0;
      divSel_reg <= 2'b00;
      srcSel_reg <= `WD_SRC_INTERNAL;
      stopped_reg <= 1'b1;
      clearPend_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      clearPend_reg <= clearCmd;
      if (regWrite && regAddr == `WD_IDX_PROTECT)
        unlocked_reg <= (regWdata == `WD_PROTECT_KEY);
      if (wrClock)
      begin
        debugRun_reg <= regWdata[`WD_DEBUG_RUN_BIT_BIT];
        divSel_reg <= regWdata[`WD_DIV_HI:`WD_DIV_LO];
        if (isSelectable(regWdata[`WD_SRC_HI:`WD_SRC_LO]))
          srcSel_reg <= regWdata[`WD_SRC_HI:`WD_SRC_LO];
      end
      if (wrControl)
        stopped_reg <= (regWdata[`WD_RUN_HI:`WD_RUN_LO]
          == `WD_RUN_STOP);
    end
  end

  // ----------------------------------------------------------------
  // Counter and reset generation
  // ----------------------------------------------------------------
  // The counter advances only while not stopped; the source, the prescaler and
  // the debug gate decide whether ticks arrive.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= {COUNT_W{1'b0}};
      systemReset <= 1'b0;
      counterClock <= 1'b0;
    end
    else if (clkEn)
    begin
      systemReset <= 1'b0;
      counterClock <= divTick & ~clockGated;
      if (clearCmd)
        count_reg <= {COUNT_W{1'b0}};
      else if (divTick && !clockGated && !stopped_reg)
      begin
        count_reg <= count_reg + 1'b1;
        if (&count_reg)
          systemReset <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 16'h0000;
    else if (clkEn)
    begin
      regRdata <= 16'h0000;
      if (regRead)
      begin
        case (regAddr)
          `WD_IDX_PROTECT: regRdata <= {15'h0000, unlocked_reg};
          `WD_IDX_CLOCK: regRdata <= {7'h00, debugRun_reg, 2'b00,
            divSel_reg, 2'b00, srcSel_reg};
          `WD_IDX_CONTROL: regRdata <= {12'h000, stopped_reg ?
            `WD_RUN_STOP : `WD_RUN_READ_RUNNING};
          `WD_IDX_COUNT: regRdata <= {{(16-COUNT_W){1'b0}}, count_reg};
          default: regRdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule

/* File: verilog/wd_prescaler.v */
`timescale 1ns/10ps
// Divides one source tick stream; emits a tick every 2^exponent ticks.
module wd_prescaler #(
  parameter WIDTH = 14
)
(
  input wire mclk,
  input wire rst_n,
  input wire clkEn,
  input wire srcTick,
  input wire [4:0] exponent,
  input wire clear,
  output reg divTick
);
  reg [WIDTH-1:0] presc_reg;
  wire [WIDTH-1:0] mask;
  assign mask = (({{(WIDTH-1){1'b0}}, 1'b1} << exponent) - 1'b1);

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_reg <= {WIDTH{1'b0}};
      divTick <= 1'b0;
    end
    else if (clkEn)
    begin
      divTick <= 1'b0;
      if (clear)
        presc_reg <= {WIDTH{1'b0}};
      else if (srcTick)
      begin
        if ((presc_reg & mask) == mask)
        begin
          presc_reg <= {WIDTH{1'b0}};
          divTick <= 1'b1;
        end
        else
          presc_reg <= presc_reg + 1'b1;
      end
    end
  end
endmodule
